// >>> common/wdog_defs.svh
/*
 * Constants of the loop detector: register addresses, field positions,
 * reset values, key values and counter exponents.
 * Assumes it is included by bare name from the package and design files.
 */
// Summary of operation
// - Counter overflow without refresh raises an internal system reset.
// - A reset caused by the watchdog sets bit 4 of the reset cause register.
// - Slow clock source: overflow after 2^11 to 2^18 cycles.
// - Main clock source: overflow after 2^13 to 2^20 cycles.
// - Unstoppable option: always count slow clock, whatever select is written.
// - Stoppable option: select main, slow or stopped; slow after reset.
// - After reset, counting starts at once with 2^18 slow cycles.
// - Unstoppable option: interval may be changed only once after reset.
// - Stoppable option: clock and interval may be changed only once together.
// - Unstoppable option: nothing can halt counting.
// - Stoppable option: software halts counting by selecting stopped.
// - Unstoppable option: slow oscillator runs whenever powered, except in reset.
// - Main source: gated while main clock stopped, in standby, or stabilizing.
// - Stoppable option, slow source: gated in standby, or CPU on main with slow osc stopped.
// - Exactly two control registers: mode and refresh.
// - Writing ACH to refresh clears the counter and restarts counting.
// - Any other refresh write resets unless stopped; refresh reads always return 9AH.
// - Second mode write resets unless first stopped; accepted write clears counter.
// - Select 00 slow, 01 main, 1x stopped; interval resets to code 111.
`ifndef WDOG_DEFS_SVH
`define WDOG_DEFS_SVH

`define WD_ADDR_W        16
`define WD_MODE_ADDR     16'hFF48
`define WD_REFRESH_ADDR  16'hFF49
`define WD_CAUSE_ADDR    16'hFF4A

`define WD_MODE_RESET    8'h67
`define WD_MODE_FIXED    3'h3
`define WD_CS_HI         4
`define WD_CS_LO         3
`define WD_IV_HI         2
`define WD_CS_SLOW       2'h0
`define WD_CS_MAIN       2'h1
`define WD_IV_MAX        3'h7
`define WD_FLAG_BIT      4

`define WD_REFRESH_KEY   8'hAC
`define WD_REFRESH_READ  8'h9A

`define WD_CNT_W         20
`define WD_EXP_W         5
`define WD_SLOW_EXP_MIN  5'h0B
`define WD_MAIN_EXP_MIN  5'h0D

`endif

// >>> common/wdog_pkg.sv
/*
 * Types shared by the loop detector modules.
 * Assumes wdog_defs.svh is on the include path.
 */
`include "wdog_defs.svh"

package wdog_pkg;
    typedef enum logic [1:0] {SRC_SLOW, SRC_MAIN, SRC_STOP} src_t;

    typedef struct packed {
        logic                 unst;
        logic                 locked;
        logic [1:0]           cs;
        logic [2:0]           iv;
        logic                 flag;
        logic                 int_reset;
        logic [7:0]           rdata;
    } ctrl_state_t;

    typedef struct packed {
        logic [`WD_CNT_W-1:0] cnt;
        logic                 ovf;
    } cnt_state_t;

    typedef struct packed {
        logic                 tick;
    } gate_state_t;
endpackage

// >>> common/wdog_link_if.sv
/*
 * Carrier between the control block, the clock gate and the counter.
 * Assumes one clock, a synchronous active-low reset and a clock enable.
 */
`timescale 1ns/1ns
`include "wdog_defs.svh"
interface wdog_link_if (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce
);
    logic                 tick;
    logic                 clr;
    logic [`WD_EXP_W-1:0] expo;
    logic                 ovf;

    modport gate    (input clk, nrst, ce, output tick);
    modport counter (input clk, nrst, ce, tick, clr, expo, output ovf);
    modport ctrl    (input tick, ovf, output clr, expo);
endinterface

// >>> verilog/wdog_tick_gate.sv
/*
 * Decides in which cycles the watchdog counter may advance.
 * Assumes slow_tick is a one-cycle pulse per slow oscillator period,
 * synchronous to clk; the main clock is clk itself.
 */
`timescale 1ns/1ns
module wdog_tick_gate
    import wdog_pkg::*;
(
    wdog_link_if.gate  link,
    input  wire src_t  src,
    input  wire logic  unst,
    input  wire logic  slow_tick,
    input  wire logic  standby,
    input  wire logic  main_stopped,
    input  wire logic  osc_stab,
    input  wire logic  cpu_on_main,
    input  wire logic  slow_osc_off
);
    gate_state_t st;
    gate_state_t next_st;

    always_comb begin
        next_st = st;
        if (!link.nrst) begin
            next_st.tick = 1'b0;
        end else if (link.ce) begin
            unique case (src)
                SRC_MAIN: next_st.tick = !(main_stopped || standby || osc_stab);
                SRC_SLOW: next_st.tick = slow_tick && (unst ||
                              !(standby || (cpu_on_main && slow_osc_off)));
                SRC_STOP: next_st.tick = 1'b0;
                default:  next_st.tick = 1'b0;
            endcase
        end
    end

    always_ff @(posedge link.clk) begin
        st <= next_st;
    end

    assign link.tick = st.tick;

    main_gated_a: assert property (@(posedge link.clk) disable iff (!link.nrst)
        link.ce && src == SRC_MAIN && (standby || osc_stab) |=> !link.tick)
        else $error("main source tick during standby or stabilization");
    unst_runs_a: assert property (@(posedge link.clk) disable iff (!link.nrst)
        link.ce && unst && slow_tick && src == SRC_SLOW |=> link.tick)
        else $error("slow tick lost with unstoppable oscillator");
endmodule

// >>> verilog/wdog_counter.sv
/*
 * Overflow counter of the watchdog.
 * Assumes expo holds the selected power of two and clr is a one-cycle request.
 */
`timescale 1ns/1ns
`include "wdog_defs.svh"
module wdog_counter
    import wdog_pkg::*;
(
    wdog_link_if.counter link
);
    cnt_state_t st;
    cnt_state_t next_st;

    // Terminal value 2^expo - 1 as a mask of low ones
    function automatic logic [`WD_CNT_W-1:0] top_of(input logic [`WD_EXP_W-1:0] e);
        logic [`WD_CNT_W-1:0] m;
        m = '0;
        for (int i = 0; i < `WD_CNT_W; i++) begin
            m[i] = (i < int'(e));
        end
        return m;
    endfunction

    always_comb begin
        next_st = st;
        if (!link.nrst) begin
            next_st = '0;
        end else if (link.ce) begin
            next_st.ovf = 1'b0;
            if (link.clr) begin
                next_st.cnt = '0;
            end else if (link.tick) begin
                if (st.cnt == top_of(link.expo)) begin
                    next_st.cnt = '0;
                    next_st.ovf = 1'b1;
                end else begin
                    next_st.cnt = st.cnt + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge link.clk) begin
        st <= next_st;
    end

    assign link.ovf = st.ovf;

    ovf_at_top_a: assert property (@(posedge link.clk) disable iff (!link.nrst)
        $rose(st.ovf) |-> $past(st.cnt) == top_of($past(link.expo)) && st.cnt == '0)
        else $error("overflow not at selected power of two");
endmodule

// >>> verilog/loop_detector.sv
/*
 * Watchdog loop detector: mode, refresh and reset cause registers,
 * write-once control, refresh key check and internal reset generation.
 * Assumes a single-cycle register port with read data one cycle later,
 * synchronous system inputs and an external reset that is the power-on
 * or pin reset; the internal reset it raises is fed to the rest of chip.
 */
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "wdog_defs.svh"
module loop_detector
    import wdog_pkg::*;
#(
    parameter logic [`WD_EXP_W-1:0] SLOW_EXP_MIN = `WD_SLOW_EXP_MIN,
    parameter logic [`WD_EXP_W-1:0] MAIN_EXP_MIN = `WD_MAIN_EXP_MIN
)(
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 ce,
    input  wire logic [`WD_ADDR_W-1:0] addr,
    input  wire logic [7:0]           wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output      logic [7:0]           rdata,
    input  wire logic                 opt_unstoppable,
    input  wire logic                 slow_tick,
    input  wire logic                 standby,
    input  wire logic                 main_stopped,
    input  wire logic                 osc_stab,
    input  wire logic                 cpu_on_main,
    input  wire logic                 slow_osc_off,
    output      logic                 internal_reset,
    output      logic                 watchdog_reset_flag
);
    ctrl_state_t st;
    ctrl_state_t next_st;
    logic        violation;
    logic        good_refresh;
    logic        mode_taken;
    src_t        src;

    wdog_link_if link (
        .clk  (clk),
        .nrst (nrst),
        .ce   (ce)
    );

    // Source actually counted; the option overrides any written select
    function automatic src_t src_of(input logic unst, input logic [1:0] cs);
        if (unst) begin
            return SRC_SLOW;
        end else if (cs[1]) begin
            return SRC_STOP;
        end else if (cs[0]) begin
            return SRC_MAIN;
        end
        return SRC_SLOW;
    endfunction

    // Overflow exponent for the source and interval code
    function automatic logic [`WD_EXP_W-1:0] expo_of(input src_t s, input logic [2:0] iv);
        if (s == SRC_MAIN) begin
            return MAIN_EXP_MIN + {2'h0, iv};
        end
        return SLOW_EXP_MIN + {2'h0, iv};
    endfunction

    assign src = src_of(st.unst, st.cs);

    wdog_tick_gate gate_i (
        .link         (link.gate),
        .src          (src),
        .unst         (st.unst),
        .slow_tick    (slow_tick),
        .standby      (standby),
        .main_stopped (main_stopped),
        .osc_stab     (osc_stab),
        .cpu_on_main  (cpu_on_main),
        .slow_osc_off (slow_osc_off)
    );

    wdog_counter counter_i (
        .link (link.counter)
    );

    always_comb begin
        next_st      = st;
        violation    = 1'b0;
        good_refresh = 1'b0;
        mode_taken   = 1'b0;
        if (!nrst) begin
            // Option is caught while reset is held, never through the reset itself
            next_st.int_reset = 1'b0;
            next_st.rdata     = 8'h00;
            next_st.unst      = opt_unstoppable;
            next_st.locked    = 1'b0;
            next_st.cs        = 2'(`WD_MODE_RESET >> `WD_CS_LO);
            next_st.iv        = `WD_IV_MAX;
            next_st.flag      = 1'b0;
        end else if (ce) begin
            // Pulses clear only on enabled cycles, so a low enable freezes them too
            next_st.int_reset = 1'b0;
            next_st.rdata     = 8'h00;
            // only the mode and refresh registers steer the watchdog
            if (rd) begin
                unique case (addr)
                    `WD_MODE_ADDR: begin
                        next_st.rdata = {`WD_MODE_FIXED, st.cs, st.iv};
                    end
                    `WD_REFRESH_ADDR: begin
                        next_st.rdata = `WD_REFRESH_READ;
                    end
                    `WD_CAUSE_ADDR: begin
                        next_st.rdata[`WD_FLAG_BIT] = st.flag;
                        // Reading clears the cause; a new watchdog reset below wins
                        next_st.flag = 1'b0;
                    end
                    default: begin
                        next_st.rdata = 8'h00;
                    end
                endcase
            end
            if (wr) begin
                unique case (addr)
                    `WD_MODE_ADDR: begin
                        if (!st.locked) begin
                            mode_taken     = 1'b1;
                            next_st.locked = 1'b1;
                            next_st.iv     = wdata[`WD_IV_HI:0];
                            // Select bits are ignored while the oscillator is unstoppable
                            next_st.cs     = st.unst ? `WD_CS_SLOW
                                                     : wdata[`WD_CS_HI:`WD_CS_LO];
                        end else if (src != SRC_STOP) begin
                            violation = 1'b1;
                        end
                    end
                    `WD_REFRESH_ADDR: begin
                        if (wdata == `WD_REFRESH_KEY) begin
                            good_refresh = 1'b1;
                        end else if (src != SRC_STOP) begin
                            violation = 1'b1;
                        end
                    end
                    default: begin
                        violation = 1'b0;
                    end
                endcase
            end
            if (violation || link.ovf) begin
                next_st.int_reset = 1'b1;
                next_st.flag      = 1'b1;
                next_st.locked    = 1'b0;
                next_st.cs        = `WD_CS_SLOW;
                next_st.iv        = `WD_IV_MAX;
            end
        end
    end

    // The internal reset restarts the count as well as the rest of the chip
    assign link.clr  = ce && (good_refresh || mode_taken || st.int_reset);
    assign link.expo = expo_of(src, st.iv);

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign rdata               = st.rdata;
    assign internal_reset      = st.int_reset;
    assign watchdog_reset_flag = st.flag;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    overflow_reset_a: assert property (
        ce && link.ovf |=> internal_reset && watchdog_reset_flag)
        else $error("overflow did not raise internal reset");

    cause_flag_a: assert property (
        internal_reset |-> watchdog_reset_flag)
        else $error("watchdog reset without cause flag");

    slow_range_a: assert property (
        src == SRC_SLOW |-> link.expo >= SLOW_EXP_MIN && link.expo <= SLOW_EXP_MIN + 5'h07)
        else $error("slow interval out of range");

    main_range_a: assert property (
        src == SRC_MAIN |-> link.expo == MAIN_EXP_MIN + {2'h0, st.iv})
        else $error("main interval wrong");

    unst_slow_a: assert property (
        st.unst |-> src == SRC_SLOW)
        else $error("unstoppable option left slow clock");

    reset_start_a: assert property (
        $rose(nrst) |-> src == SRC_SLOW && st.iv == `WD_IV_MAX && !st.locked)
        else $error("not at maximum interval after reset");

    second_write_a: assert property (
        ce && wr && addr == `WD_MODE_ADDR && st.locked && src != SRC_STOP
        |=> internal_reset)
        else $error("second mode write tolerated");

    mode_once_a: assert property (
        ce && wr && addr == `WD_MODE_ADDR && st.locked
        |=> st.iv == `WD_IV_MAX || $stable(st.iv))
        else $error("interval changed twice");

    stop_quiet_a: assert property (
        src == SRC_STOP ##1 src == SRC_STOP |-> !link.tick ##1 !link.ovf)
        else $error("stopped watchdog still counts");

    bad_key_a: assert property (
        ce && wr && addr == `WD_REFRESH_ADDR && wdata != `WD_REFRESH_KEY
        && src != SRC_STOP |=> internal_reset)
        else $error("wrong refresh key did not reset");

    refresh_read_a: assert property (
        ce && rd && addr == `WD_REFRESH_ADDR |=> rdata == `WD_REFRESH_READ)
        else $error("refresh register read wrong");

    refresh_clear_a: assert property (
        ce && wr && addr == `WD_REFRESH_ADDR && wdata == `WD_REFRESH_KEY |-> link.clr)
        else $error("refresh did not clear counter");

    mode_read_a: assert property (
        ce && rd && addr == `WD_MODE_ADDR
        |=> rdata == {`WD_MODE_FIXED, $past(st.cs), $past(st.iv)})
        else $error("mode readback wrong");

    no_halt_a: assert property (
        st.unst |-> src != SRC_STOP)
        else $error("unstoppable watchdog halted");

    overflow_c: cover property (link.ovf ##1 internal_reset);
    refresh_c: cover property (ce && wr && addr == `WD_REFRESH_ADDR
        && wdata == `WD_REFRESH_KEY);
    stopped_c: cover property (src == SRC_STOP ##1 ce && wr && addr == `WD_MODE_ADDR);
    main_src_c: cover property (src == SRC_MAIN && link.tick);
endmodule

// >>> bench/tb_top.sv
/*
 * Self-checking bench of the loop detector: register reads and writes,
 * overflow periods of both sources, refresh, write-once mode, stop and gating.
 * Assumes the design files compile with wdog_defs.svh on the include path;
 * counts are shortened through SLOW_EXP_MIN and MAIN_EXP_MIN.
 */
`timescale 1ns/1ns
`include "wdog_defs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error at %0t ns: got %0h, expected %0h", $time, (g), (e)); end end

module tb_top;
    localparam int                 SE = 2;
    localparam int                 ME = 3;
    logic                          clk = 1'b0;
    logic                          nrst = 1'b0;
    logic                          ce = 1'b1;
    logic                          wr = 1'b0;
    logic                          rd = 1'b0;
    logic                          opt_unstoppable = 1'b0;
    logic                          slow_tick = 1'b0;
    logic                          standby = 1'b0;
    logic                          main_stopped = 1'b0;
    logic                          osc_stab = 1'b0;
    logic                          cpu_on_main = 1'b0;
    logic                          slow_osc_off = 1'b0;
    logic [`WD_ADDR_W-1:0]         addr = '0;
    logic [7:0]                    wdata = 8'h00;
    logic [7:0]                    rdata;
    logic                          internal_reset;
    logic                          watchdog_reset_flag;
    logic [1:0]                    div = 2'h0;
    int                            n_mismatch = 0;
    int                            num_checks = 0;
    int                            n;
    logic [4:0]                    gates [5] = '{5'h01, 5'h02, 5'h04, 5'h01, 5'h18};
    logic [7:0]                    gmode [5] = '{8'h68, 8'h68, 8'h68, 8'h60, 8'h60};

    loop_detector #(
        .SLOW_EXP_MIN (5'(SE)),
        .MAIN_EXP_MIN (5'(ME))
    ) loop_detector_i (
        .clk                 (clk),
        .nrst                (nrst),
        .ce                  (ce),
        .addr                (addr),
        .wdata               (wdata),
        .wr                  (wr),
        .rd                  (rd),
        .rdata               (rdata),
        .opt_unstoppable     (opt_unstoppable),
        .slow_tick           (slow_tick),
        .standby             (standby),
        .main_stopped        (main_stopped),
        .osc_stab            (osc_stab),
        .cpu_on_main         (cpu_on_main),
        .slow_osc_off        (slow_osc_off),
        .internal_reset      (internal_reset),
        .watchdog_reset_flag (watchdog_reset_flag)
    );

    always #5 clk = ~clk;

    // Slow oscillator stand-in: one tick every four system clocks
    always @(posedge clk) begin
        div <= div + 2'h1;
        slow_tick <= (div == 2'h3);
    end

    function automatic logic near(int v, int t, int lo, int hi);
        return (v >= t - lo) && (v <= t + hi);
    endfunction

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe edge
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask

    // Cycles until the internal reset pulse, bounded by lim
    task automatic measure(input int lim);
        n = 0;
        #1;
        while (internal_reset !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic do_reset(input logic opt);
        @(posedge clk);
        nrst <= 1'b0;
        opt_unstoppable <= opt;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
    endtask

    task automatic wrap_up;
        $display("Checks: %0d, mismatches: %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #900000;
        n_mismatch++;
        $display("Error at %0t ns: run timed out", $time);
        wrap_up();
    end

    initial begin
        do_reset(1'b0);
        measure(20000);
        `CHK(near(n, 4 * 2 ** (SE + 7), 6, 10), 1'b1)
        `CHK(watchdog_reset_flag, 1'b1)
        rd_reg(`WD_CAUSE_ADDR, 8'h10);
        rd_reg(`WD_CAUSE_ADDR, 8'h00);
        rd_reg(`WD_MODE_ADDR, 8'h67);
        rd_reg(`WD_REFRESH_ADDR, 8'h9A);
        rd_reg(16'hFF50, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr_reg(`WD_MODE_ADDR, {3'b011, 2'b00, i[2:0]});
            measure(20000);
            `CHK(near(n, 4 * 2 ** (SE + i), 6, 10), 1'b1)
        end
        for (int i = 0; i < 8; i++) begin
            wr_reg(`WD_MODE_ADDR, {3'b011, 2'b01, i[2:0]});
            measure(5000);
            `CHK(near(n, 2 ** (ME + i), 1, 4), 1'b1)
        end
        wr_reg(`WD_MODE_ADDR, 8'h6B);
        rd_reg(`WD_MODE_ADDR, 8'h6B);
        wr_reg(`WD_MODE_ADDR, 8'h6B);
        measure(10);
        `CHK(n <= 2, 1'b1)
        wr_reg(`WD_MODE_ADDR, 8'h6B);
        repeat (6) begin
            measure(40);
            `CHK(n, 40)
            wr_reg(`WD_REFRESH_ADDR, `WD_REFRESH_KEY);
        end
        rd_reg(`WD_REFRESH_ADDR, 8'h9A);
        wr_reg(`WD_REFRESH_ADDR, 8'h55);
        measure(10);
        `CHK(n <= 2, 1'b1)
        rd_reg(`WD_CAUSE_ADDR, 8'h10);
        // A strobe without clock enable must not be taken
        @(posedge clk) ce <= 1'b0;
        wr_reg(`WD_REFRESH_ADDR, 8'h00);
        @(posedge clk) ce <= 1'b1;
        measure(5);
        `CHK(n, 5)
        wr_reg(`WD_MODE_ADDR, 8'h70);
        measure(3000);
        `CHK(n, 3000)
        wr_reg(`WD_MODE_ADDR, 8'h68);
        wr_reg(`WD_REFRESH_ADDR, 8'h00);
        measure(100);
        `CHK(n, 100)
        rd_reg(`WD_MODE_ADDR, 8'h70);
        do_reset(1'b0);
        for (int k = 0; k < 5; k++) begin
            wr_reg(`WD_MODE_ADDR, gmode[k]);
            @(posedge clk) {slow_osc_off, cpu_on_main, osc_stab, main_stopped, standby} <= gates[k];
            measure(300);
            `CHK(n, 300)
            @(posedge clk) {slow_osc_off, cpu_on_main, osc_stab, main_stopped, standby} <= 5'h00;
            measure(100);
            `CHK(n <= 40, 1'b1)
        end
        do_reset(1'b1);
        rd_reg(`WD_MODE_ADDR, 8'h67);
        wr_reg(`WD_MODE_ADDR, 8'h70);
        rd_reg(`WD_MODE_ADDR, 8'h60);
        @(posedge clk) standby <= 1'b1;
        measure(200);
        `CHK(near(n, 12, 6, 10), 1'b1)
        wr_reg(`WD_MODE_ADDR, 8'h77);
        wr_reg(`WD_MODE_ADDR, 8'h77);
        measure(10);
        `CHK(n <= 2, 1'b1)
        @(posedge clk) standby <= 1'b0;
        wrap_up();
    end
endmodule
